/* File: logic/efl_pkg.sv */
`default_nettype none
package efl_pkg;
   localparam int LANES = 20;
   localparam int SPACING_W = 16;
   localparam int MARKER_W = 64;
   localparam logic [15:0] SPACING_M1_RST = 16'h3FFF;
   localparam logic [19:0][63:0] MARKER_RST = '{
      64'hC0F0E5003F0F1A00, 64'h5F662A00A099D500,
      64'hADD6B70052294800, 64'hC4314C003BCEB300,
      64'h3536CD00CAC93200, 64'h83C7CA007C383500,
      64'h1AF8BD00E5074200, 64'h5CB9B200A3464D00,
      64'hB9915500466EAA00, 64'hFD6C990002936600,
      64'h68C9FB0097360400, 64'hA02476005FDB8900,
      64'h7B45660084BA9900, 64'h9A4A260065B5D900,
      64'hDD14C20022EB3D00, 64'hF50709000AF8F600,
      64'h4D957B00B26A8400, 64'h594BE800A6B41700,
      64'h9D718E00628E7100, 64'hC16821003E97DE00};
   localparam logic TX_INS_RST = 1'b1;
   localparam logic TX_IGNORE_RST = 1'b0;
   localparam logic RX_PRE_CHK_RST = 1'b0;
   localparam logic RX_SFD_CHK_RST = 1'b0;
   localparam logic RX_STRIP_RST = 1'b1;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY_REFL = 32'hEDB88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hD5;
   localparam logic [2:0] HDR_LAST = 3'h7;
   localparam logic [3:0] STRIP_MIN_PRIOR = 4'h8;
   localparam logic [2:0] FCS_BYTES = 3'h4;
   localparam logic [1:0] FCS_LAST = 2'h3;
   localparam int REG_AW = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_CFG = 4'h8;
   localparam int STAT_W = 4;
   localparam int ST_TX_BAD = 0;
   localparam int ST_RX_PRE = 1;
   localparam int ST_RX_SFD = 2;
   localparam int ST_TX_GOOD = 3;
   localparam logic [3:0] MASK_RST = 4'h0;
endpackage
`default_nettype wire

/* File: logic/efl_crc.sv */
`default_nettype none
module efl_crc (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic init,
   input wire logic en,
   input wire logic [7:0] data,
   output logic [31:0] crc_q
);
   // reflected form, bit 0 of each byte first
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ efl_pkg::CRC_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   always_ff @(posedge clk) begin
      if (!nrst) begin
         crc_q <= efl_pkg::CRC_INIT;
      end else if (ce && en) begin
         crc_q <= crc_byte(init ? efl_pkg::CRC_INIT : crc_q, data);
      end
   end
endmodule // efl_crc
`default_nettype wire

/* File: logic/efl_marker.sv */
`default_nettype none
module efl_marker #(
   parameter int N_LANES = efl_pkg::LANES,
   parameter int LW = $clog2(efl_pkg::LANES)
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [efl_pkg::SPACING_W-1:0] spacing_m1,
   input wire logic [N_LANES-1:0][efl_pkg::MARKER_W-1:0] markers,
   output logic strobe_q,
   output logic [LW-1:0] lane_q,
   output logic [efl_pkg::MARKER_W-1:0] value_q
);
   typedef enum logic {MK_COUNT = 1'b0, MK_EMIT = 1'b1} efl_mk_state_t;
   efl_mk_state_t state_q;
   logic [efl_pkg::SPACING_W-1:0] cnt_q;
   logic [LW-1:0] lane_cnt_q;

   if (N_LANES < 2 || (1 << LW) < N_LANES) begin : g_chk
      $error("efl_marker: lane count does not fit the lane index");
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= MK_COUNT;
         cnt_q <= '0;
         lane_cnt_q <= '0;
      end else if (ce) begin
         case (state_q)
            MK_COUNT: begin
               // >= so a smaller spacing loaded mid-count still wraps
               if (cnt_q >= spacing_m1) begin
                  cnt_q <= '0;
                  lane_cnt_q <= '0;
                  state_q <= MK_EMIT;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            MK_EMIT: begin
               if (lane_cnt_q == LW'(N_LANES - 1)) begin
                  state_q <= MK_COUNT;
               end
               lane_cnt_q <= lane_cnt_q + 1'b1;
            end
            default: state_q <= MK_COUNT;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         strobe_q <= 1'b0;
         lane_q <= '0;
         value_q <= '0;
      end else if (ce) begin
         strobe_q <= (state_q == MK_EMIT);
         lane_q <= lane_cnt_q;
         value_q <= markers[lane_cnt_q];
      end
   end
endmodule // efl_marker
`default_nettype wire

/* File: logic/efl_top.sv */
`default_nettype none
// Overview of operation
// - with insertion on, a computed checksum is appended; on by default.
// - the bad-checksum ignore setting matters only while insertion is off.
// - insertion off, a bad supplied checksum is good only under ignore.
// - a bad checksum pulses bad and stomped; the packet goes out unchanged.
// - under ignore the statistics count the bad packet as good, yet still flag it bad.
// - tx markers are spaced by a 16-bit words-minus-one count, default 16383.
// - each lane sends its own programmable 64-bit marker, lane 0 first.
// - all twenty lanes have own marker settings with standard defaults.
// - with preamble check on, each preamble is verified; off by default.
// - with delimiter check on, each delimiter is verified; off by default.
// - with strip on (default) rx drops the checksum, else keeps it.
// - packets of at most 8 bytes keep their checksum even with strip on.
// - the receive side has its own 16-bit spacing count, default 16383.
module efl_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cfg_load,
   input wire logic tx_checksum_ins_en,
   input wire logic tx_ignore_bad_checksum,
   input wire logic [15:0] tx_marker_spacing_m1,
   input wire logic [efl_pkg::LANES-1:0][63:0] tx_lane_marker_value,
   input wire logic rx_preamble_check_en,
   input wire logic rx_delimiter_check_en,
   input wire logic rx_checksum_strip_en,
   input wire logic [15:0] rx_marker_spacing_m1,
   input wire logic tx_in_valid,
   input wire logic [7:0] tx_in_data,
   input wire logic tx_in_sop,
   input wire logic tx_in_eop,
   output logic tx_in_ready_q,
   output logic tx_out_valid_q,
   output logic [7:0] tx_out_data_q,
   output logic tx_out_sop_q,
   output logic tx_out_eop_q,
   output logic tx_bad_checksum_pulse_q,
   output logic stomped_checksum_pulse_q,
   output logic tx_good_pkt_pulse_q,
   output logic tx_marker_strobe_q,
   output logic [4:0] tx_marker_lane_q,
   output logic [63:0] tx_marker_value_q,
   input wire logic rx_in_valid,
   input wire logic [7:0] rx_in_data,
   input wire logic rx_in_sop,
   input wire logic rx_in_eop,
   output logic rx_out_valid_q,
   output logic [7:0] rx_out_data_q,
   output logic rx_out_sop_q,
   output logic rx_out_eop_q,
   output logic rx_preamble_err_pulse_q,
   output logic rx_delimiter_err_pulse_q,
   output logic rx_marker_due_q,
   output logic [4:0] rx_marker_lane_q,
   input wire logic [efl_pkg::REG_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   output logic irq_q
);
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_FCS = 2'b11
   } efl_tx_state_t;
   typedef enum logic [1:0] {
      RX_HDR = 2'b00,
      RX_PAY = 2'b01,
      RX_FLUSH = 2'b11
   } efl_rx_state_t;

   logic tx_ins_en_q, tx_ignore_q, rx_pre_en_q, rx_sfd_en_q, rx_strip_q;
   logic [15:0] tx_spacing_q, rx_spacing_q;
   logic [efl_pkg::LANES-1:0][63:0] tx_markers_q;
   efl_tx_state_t tx_state_q;
   efl_rx_state_t rx_state_q;
   logic [1:0] tx_fcs_idx_q;
   logic [31:0] tx_crc_q, tx_crc_inv;
   logic tx_acc, tx_chk_q, tx_bad, tx_fcs_done;
   logic rx_acc, rx_first_q, rx_pre_bad_q;
   logic [2:0] rx_hdr_cnt_q, rx_fill_q;
   logic [3:0] rx_len_q;
   logic [3:0][7:0] rx_sh_q;
   logic [efl_pkg::STAT_W-1:0] status_q, mask_q, events;

   assign tx_acc = tx_in_valid && tx_in_ready_q;
   assign tx_crc_inv = ~tx_crc_q;
   assign tx_bad = tx_chk_q && (tx_crc_q != efl_pkg::CRC_RESIDUE);
   assign tx_fcs_done = (tx_state_q == TX_FCS) &&
                        (tx_fcs_idx_q == efl_pkg::FCS_LAST);
   assign rx_acc = rx_in_valid && (rx_state_q != RX_FLUSH);

   // tx settings only move between packets so a frame never sees a mix
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_ins_en_q <= efl_pkg::TX_INS_RST;
         tx_ignore_q <= efl_pkg::TX_IGNORE_RST;
      end else if (ce && cfg_load && tx_state_q == TX_IDLE && !tx_in_valid)
      begin
         tx_ins_en_q <= tx_checksum_ins_en;
         tx_ignore_q <= tx_ignore_bad_checksum;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_pre_en_q <= efl_pkg::RX_PRE_CHK_RST;
         rx_sfd_en_q <= efl_pkg::RX_SFD_CHK_RST;
         rx_strip_q <= efl_pkg::RX_STRIP_RST;
      end else if (ce && cfg_load && rx_state_q == RX_HDR &&
                   rx_hdr_cnt_q == 3'h0) begin
         rx_pre_en_q <= rx_preamble_check_en;
         rx_sfd_en_q <= rx_delimiter_check_en;
         rx_strip_q <= rx_checksum_strip_en;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_spacing_q <= efl_pkg::SPACING_M1_RST;
         rx_spacing_q <= efl_pkg::SPACING_M1_RST;
         tx_markers_q <= efl_pkg::MARKER_RST;
      end else if (ce && cfg_load) begin
         tx_spacing_q <= tx_marker_spacing_m1;
         rx_spacing_q <= rx_marker_spacing_m1;
         tx_markers_q <= tx_lane_marker_value;
      end
   end

   efl_crc u_tx_crc (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .init(tx_state_q == TX_IDLE),
      .en(tx_acc),
      .data(tx_in_data),
      .crc_q(tx_crc_q)
   );

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_state_q <= TX_IDLE;
         tx_in_ready_q <= 1'b1;
         tx_fcs_idx_q <= 2'h0;
         tx_out_valid_q <= 1'b0;
         tx_out_data_q <= 8'h00;
         tx_out_sop_q <= 1'b0;
         tx_out_eop_q <= 1'b0;
      end else if (ce) begin
         tx_out_valid_q <= 1'b0;
         tx_out_sop_q <= 1'b0;
         tx_out_eop_q <= 1'b0;
         case (tx_state_q)
            TX_IDLE, TX_DATA: begin
               if (tx_acc) begin
                  // user bytes pass untouched, bad checksum or not
                  tx_out_valid_q <= 1'b1;
                  tx_out_data_q <= tx_in_data;
                  tx_out_sop_q <= (tx_state_q == TX_IDLE);
                  tx_out_eop_q <= tx_in_eop && !tx_ins_en_q;
                  if (tx_in_eop && tx_ins_en_q) begin
                     tx_in_ready_q <= 1'b0;
                     tx_fcs_idx_q <= 2'h0;
                     tx_state_q <= TX_FCS;
                  end else if (tx_in_eop) begin
                     tx_state_q <= TX_IDLE;
                  end else begin
                     tx_state_q <= TX_DATA;
                  end
               end
            end
            TX_FCS: begin
               tx_out_valid_q <= 1'b1;
               tx_out_data_q <= tx_crc_inv[{tx_fcs_idx_q,3'b000}+:8];
               tx_out_eop_q <= tx_fcs_done;
               tx_fcs_idx_q <= tx_fcs_idx_q + 2'h1;
               if (tx_fcs_done) begin
                  tx_in_ready_q <= 1'b1;
                  tx_state_q <= TX_IDLE;
               end
            end
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   // supplied checksum is judged one cycle after its last byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_chk_q <= 1'b0;
         tx_bad_checksum_pulse_q <= 1'b0;
         stomped_checksum_pulse_q <= 1'b0;
         tx_good_pkt_pulse_q <= 1'b0;
      end else if (ce) begin
         tx_chk_q <= tx_acc && tx_in_eop && !tx_ins_en_q;
         tx_bad_checksum_pulse_q <= tx_bad;
         stomped_checksum_pulse_q <= tx_bad;
         // ignore only reaches the counter through the insertion-off check
         tx_good_pkt_pulse_q <= (tx_chk_q && (!tx_bad || tx_ignore_q)) ||
                                tx_fcs_done;
      end
   end

   efl_marker u_tx_marker (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .spacing_m1(tx_spacing_q),
      .markers(tx_markers_q),
      .strobe_q(tx_marker_strobe_q),
      .lane_q(tx_marker_lane_q),
      .value_q(tx_marker_value_q)
   );

   efl_marker u_rx_marker (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .spacing_m1(rx_spacing_q),
      .markers(efl_pkg::MARKER_RST),
      .strobe_q(rx_marker_due_q),
      .lane_q(rx_marker_lane_q),
      .value_q()
   );

   // four-byte delay holds back what may turn out to be the checksum
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_state_q <= RX_HDR;
         rx_hdr_cnt_q <= 3'h0;
         rx_pre_bad_q <= 1'b0;
         rx_fill_q <= 3'h0;
         rx_len_q <= 4'h0;
         rx_sh_q <= '0;
         rx_first_q <= 1'b0;
         rx_out_valid_q <= 1'b0;
         rx_out_data_q <= 8'h00;
         rx_out_sop_q <= 1'b0;
         rx_out_eop_q <= 1'b0;
         rx_preamble_err_pulse_q <= 1'b0;
         rx_delimiter_err_pulse_q <= 1'b0;
      end else if (ce) begin
         rx_out_valid_q <= 1'b0;
         rx_out_sop_q <= 1'b0;
         rx_out_eop_q <= 1'b0;
         rx_preamble_err_pulse_q <= 1'b0;
         rx_delimiter_err_pulse_q <= 1'b0;
         if (rx_acc && rx_in_sop) begin
            rx_state_q <= RX_HDR;
            rx_hdr_cnt_q <= 3'h1;
            rx_pre_bad_q <= rx_pre_en_q &&
                            rx_in_data != efl_pkg::PREAMBLE_BYTE;
            rx_fill_q <= 3'h0;
            rx_len_q <= 4'h0;
            rx_first_q <= 1'b1;
         end else begin
            case (rx_state_q)
               RX_HDR: begin
                  if (rx_acc && rx_hdr_cnt_q != 3'h0) begin
                     if (rx_in_eop) begin
                        rx_hdr_cnt_q <= 3'h0;
                     end else if (rx_hdr_cnt_q != efl_pkg::HDR_LAST) begin
                        rx_hdr_cnt_q <= rx_hdr_cnt_q + 3'h1;
                        if (rx_pre_en_q &&
                            rx_in_data != efl_pkg::PREAMBLE_BYTE) begin
                           rx_pre_bad_q <= 1'b1;
                        end
                     end else begin
                        rx_preamble_err_pulse_q <= rx_pre_bad_q;
                        rx_delimiter_err_pulse_q <= rx_sfd_en_q &&
                           rx_in_data != efl_pkg::SFD_BYTE;
                        rx_hdr_cnt_q <= 3'h0;
                        rx_state_q <= RX_PAY;
                     end
                  end
               end
               RX_PAY: begin
                  if (rx_acc) begin
                     if (rx_len_q != efl_pkg::STRIP_MIN_PRIOR) begin
                        rx_len_q <= rx_len_q + 4'h1;
                     end
                     if (rx_fill_q == efl_pkg::FCS_BYTES) begin
                        rx_out_valid_q <= 1'b1;
                        rx_out_data_q <= rx_sh_q[3];
                        rx_out_sop_q <= rx_first_q;
                        rx_first_q <= 1'b0;
                     end
                     rx_sh_q <= {rx_sh_q[2:0], rx_in_data};
                     if (rx_fill_q != efl_pkg::FCS_BYTES) begin
                        rx_fill_q <= rx_fill_q + 3'h1;
                     end
                     if (rx_in_eop && rx_strip_q &&
                         rx_len_q == efl_pkg::STRIP_MIN_PRIOR) begin
                        rx_out_eop_q <= 1'b1;
                        rx_fill_q <= 3'h0;
                        rx_state_q <= RX_HDR;
                     end else if (rx_in_eop) begin
                        rx_state_q <= RX_FLUSH;
                     end
                  end
               end
               RX_FLUSH: begin
                  rx_out_valid_q <= 1'b1;
                  rx_out_data_q <= rx_sh_q[2'(rx_fill_q - 3'h1)];
                  rx_out_sop_q <= rx_first_q;
                  rx_first_q <= 1'b0;
                  rx_out_eop_q <= (rx_fill_q == 3'h1);
                  rx_fill_q <= rx_fill_q - 3'h1;
                  if (rx_fill_q == 3'h1) begin
                     rx_state_q <= RX_HDR;
                  end
               end
               default: rx_state_q <= RX_HDR;
            endcase
         end
      end
   end

   always_comb begin
      events = '0;
      events[efl_pkg::ST_TX_BAD] = tx_bad_checksum_pulse_q;
      events[efl_pkg::ST_RX_PRE] = rx_preamble_err_pulse_q;
      events[efl_pkg::ST_RX_SFD] = rx_delimiter_err_pulse_q;
      events[efl_pkg::ST_TX_GOOD] = tx_good_pkt_pulse_q;
   end

   // a new event beats a write-one clear landing in the same cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_q <= '0;
         mask_q <= efl_pkg::MASK_RST;
         irq_q <= 1'b0;
      end else if (ce) begin
         if (reg_wr && reg_addr == efl_pkg::REG_STATUS) begin
            status_q <= (status_q & ~reg_wdata[efl_pkg::STAT_W-1:0]) | events;
         end else begin
            status_q <= status_q | events;
         end
         if (reg_wr && reg_addr == efl_pkg::REG_MASK) begin
            mask_q <= reg_wdata[efl_pkg::STAT_W-1:0];
         end
         irq_q <= |(status_q & mask_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata_q <= 32'h00000000;
      end else if (ce) begin
         reg_rdata_q <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               efl_pkg::REG_STATUS:
                  reg_rdata_q <= {{(32 - efl_pkg::STAT_W){1'b0}}, status_q};
               efl_pkg::REG_MASK:
                  reg_rdata_q <= {{(32 - efl_pkg::STAT_W){1'b0}}, mask_q};
               efl_pkg::REG_CFG:
                  reg_rdata_q <= {27'h0000000, rx_strip_q, rx_sfd_en_q,
                                  rx_pre_en_q, tx_ignore_q, tx_ins_en_q};
               default: reg_rdata_q <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // efl_top
`default_nettype wire

/* File: test/efl_top_props.sv */
`default_nettype none
module efl_top_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_in_valid,
   input wire logic [7:0] tx_in_data,
   input wire logic tx_in_ready_q,
   input wire logic tx_out_valid_q,
   input wire logic [7:0] tx_out_data_q,
   input wire logic tx_bad_checksum_pulse_q,
   input wire logic stomped_checksum_pulse_q,
   input wire logic [efl_pkg::LANES-1:0][63:0] tx_lane_marker_value,
   input wire logic [15:0] tx_marker_spacing_m1,
   input wire logic tx_marker_strobe_q,
   input wire logic [4:0] tx_marker_lane_q,
   input wire logic [63:0] tx_marker_value_q,
   input wire logic rx_marker_due_q,
   input wire logic [4:0] rx_marker_lane_q,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_stomp;
      tx_bad_checksum_pulse_q == stomped_checksum_pulse_q;
   endproperty
   a_stomp: assert property (p_stomp) else $error("stomp differs");
   property p_pass;
      tx_in_valid && tx_in_ready_q |=> tx_out_valid_q &&
         tx_out_data_q == $past(tx_in_data);
   endproperty
   a_pass: assert property (p_pass) else $error("byte changed");
   property p_rdz;
      !reg_rd |=> reg_rdata_q == 32'h0;
   endproperty
   a_rdz: assert property (p_rdz) else $error("read data stale");
   property p_mval;
      tx_marker_strobe_q |->
         tx_marker_value_q == tx_lane_marker_value[tx_marker_lane_q];
   endproperty
   a_mval: assert property (p_mval) else $error("marker value");
   property p_mfirst;
      $rose(tx_marker_strobe_q) |-> tx_marker_lane_q == 5'h0;
   endproperty
   a_mfirst: assert property (p_mfirst) else $error("first lane");
   property p_mstep;
      tx_marker_strobe_q && tx_marker_lane_q != 5'h13 |=>
         tx_marker_strobe_q && tx_marker_lane_q == $past(tx_marker_lane_q)+5'h1;
   endproperty
   a_mstep: assert property (p_mstep) else $error("lane step");
   // only the short spacing that the bench loads is judged, to within one cycle
   property p_mgap;
      tx_marker_strobe_q && tx_marker_lane_q == 5'h13 &&
         tx_marker_spacing_m1 == 16'h4 |=>
         !tx_marker_strobe_q [*4] ##[1:2] tx_marker_strobe_q;
   endproperty
   a_mgap: assert property (p_mgap) else $error("marker gap");
   property p_rxfirst;
      $rose(rx_marker_due_q) |-> rx_marker_lane_q == 5'h0;
   endproperty
   a_rxfirst: assert property (p_rxfirst) else $error("rx lane");
endmodule // efl_top_props
bind efl_top efl_top_props i_props (.clk, .nrst, .tx_in_valid, .tx_in_data,
   .tx_in_ready_q, .tx_out_valid_q, .tx_out_data_q, .tx_bad_checksum_pulse_q,
   .stomped_checksum_pulse_q, .tx_lane_marker_value, .tx_marker_spacing_m1,
   .tx_marker_strobe_q, .tx_marker_lane_q, .tx_marker_value_q,
   .rx_marker_due_q, .rx_marker_lane_q, .reg_rd, .reg_rdata_q);
`default_nettype wire

/* File: test/efl_src.sv */
`default_nettype none
module efl_src (
   input wire logic clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic [7:0] n,
   input wire logic ready,
   output logic valid,
   output logic [7:0] data,
   output logic sop,
   output logic eop
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] i_q = 8'h0;
   logic v_q = 1'b0;
   // bytes 8'h10 upward, each held until taken
   always @(posedge clk) begin
      if (!nrst) begin
         v_q <= 1'b0;
      end else if (go && !v_q) begin
         v_q <= 1'b1;
         i_q <= 8'h0;
      end else if (v_q && ready) begin
         v_q <= i_q != n - 8'h1;
         i_q <= i_q + 8'h1;
      end
   end
   // idle lines show the inverse of the last byte, never a stale copy
   assign data = v_q ? 8'h10 + i_q : ~(8'h0F + i_q);
   assign valid = v_q;
   assign sop = v_q && i_q == 8'h0;
   assign eop = v_q && i_q == n - 8'h1;
endmodule // efl_src
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ld = 1'b0;
   logic [4:0] st = 5'h11;
   logic [15:0] sp = 16'h3FFF;
   logic [19:0][63:0] mk = efl_pkg::MARKER_RST;
   logic rv = 1'b0, rs = 1'b0, re = 1'b0, wr = 1'b0, rr = 1'b0, go = 1'b0;
   logic [7:0] rd = 8'h0, n = 8'h0, rf, td, od, rod;
   logic [3:0] ra = 4'h0;
   logic [31:0] wd = 32'h0, q, rq, f;
   logic tv, ts, te, rdy, ov, bad, good, ms, rov, ros, pe, se, irq, oe;
   logic [4:0] ml;
   logic [63:0] mvq;
   logic [7:0] txb [0:255];
   logic [63:0] mv [0:19];
   int n_mismatch = 0, compares = 0;
   int ntx = 0, nrx = 0, nb = 0, ng = 0, np = 0, ns = 0, nmk = 0, cyc = 0;
   int ne = 0;
   always #50 clk = ~clk;
   efl_top i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .cfg_load(ld),
      .tx_checksum_ins_en(st[0]), .tx_ignore_bad_checksum(st[1]),
      .tx_marker_spacing_m1(sp), .tx_lane_marker_value(mk),
      .rx_preamble_check_en(st[2]), .rx_delimiter_check_en(st[3]),
      .rx_checksum_strip_en(st[4]), .rx_marker_spacing_m1(sp),
      .tx_in_valid(tv), .tx_in_data(td), .tx_in_sop(ts), .tx_in_eop(te),
      .tx_in_ready_q(rdy), .tx_out_valid_q(ov), .tx_out_data_q(od),
      .tx_out_sop_q(), .tx_out_eop_q(oe), .tx_bad_checksum_pulse_q(bad),
      .stomped_checksum_pulse_q(), .tx_good_pkt_pulse_q(good),
      .tx_marker_strobe_q(ms), .tx_marker_lane_q(ml),
      .tx_marker_value_q(mvq), .rx_in_valid(rv), .rx_in_data(rd),
      .rx_in_sop(rs), .rx_in_eop(re), .rx_out_valid_q(rov),
      .rx_out_data_q(rod), .rx_out_sop_q(ros), .rx_out_eop_q(),
      .rx_preamble_err_pulse_q(pe), .rx_delimiter_err_pulse_q(se),
      .rx_marker_due_q(), .rx_marker_lane_q(), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rr), .reg_rdata_q(rq),
      .irq_q(irq));
   efl_src i_src (.clk(clk), .nrst(nrst), .go(go), .n(n), .ready(rdy),
      .valid(tv), .data(td), .sop(ts), .eop(te));
   always @(posedge clk) begin
      cyc++;
      nb += int'(bad === 1'b1);
      ng += int'(good === 1'b1);
      ne += int'(oe === 1'b1);
      np += int'(pe === 1'b1);
      ns += int'(se === 1'b1);
      nrx += int'(rov === 1'b1);
      if (rov === 1'b1 && ros === 1'b1) rf = rod;
      if (ms === 1'b1) mv[ml] = mvq;
      nmk += int'(ms === 1'b1 && ml === 5'h0);
      if (ov === 1'b1) txb[ntx] = od;
      ntx += int'(ov === 1'b1);
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      ra <= a;
      rr <= 1'b1;
      @(posedge clk);
      rr <= 1'b0;
      @(posedge clk);
      q = rq;
   endtask
   // each stream takes its own settings only while it is idle; spacing and markers load at once
   task automatic cfg(input logic [4:0] v);
      @(posedge clk);
      st <= v;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
   endtask
   task automatic tx(input logic [7:0] len, input int eo, eb, eg);
      int t0, b0, g0;
      t0 = ntx;
      b0 = nb;
      g0 = ng;
      @(posedge clk);
      n <= len;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 60 && tv === 1'b1; k++) @(posedge clk);
      repeat (8) @(posedge clk);
      chk(ntx - t0, eo);
      chk(nb - b0, eb);
      chk(ng - g0, eg);
   endtask
   task automatic rx(input int len, input logic [7:0] p, s, input int eo, ep,
                     es);
      int n0, p0, s0;
      n0 = nrx;
      p0 = np;
      s0 = ns;
      for (int i = 0; i < len + 8; i++) begin
         @(posedge clk);
         rv <= 1'b1;
         rs <= (i == 0);
         re <= (i == len + 7);
         rd <= (i < 7) ? p : ((i == 7) ? s : 8'h40 + 8'(i));
      end
      @(posedge clk);
      rv <= 1'b0;
      re <= 1'b0;
      rd <= ~rd;
      repeat (10) @(posedge clk);
      if (eo >= 0) chk(nrx - n0, eo);
      chk(np - p0, ep);
      chk(ns - s0, es);
   endtask
   function automatic logic [31:0] fcs(input int len);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < len; i++) begin
         c = c ^ {24'h0, 8'h10 + 8'(i)};
         for (int b = 0; b < 8; b++) c = c[0] ? (c>>1) ^ 32'hEDB88320 : c>>1;
      end
      return ~c;
   endfunction
   task automatic end_sim();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      sp <= 16'h4;
      mk[10] <= 64'h0123456789ABCDEF;
      rreg(efl_pkg::REG_CFG);
      chk(q, 32'h11);
      rreg(4'hC);
      chk(q, 32'h0);
      cfg(5'h11);
      tx(8'h3, 7, 0, 1);
      f = fcs(3);
      for (int k = 0; k < 4; k++) chk(txb[ntx-4+k], f[8 * k +: 8]);
      $display("END tx insert");
      cfg(5'h10);
      tx(8'h6, 6, 1, 0);
      chk(txb[ntx - 1], 8'h15);
      rreg(efl_pkg::REG_STATUS);
      chk(q, 32'h9);
      chk(irq, 1'b0);
      wreg(efl_pkg::REG_MASK, 32'h1);
      rreg(efl_pkg::REG_MASK);
      chk(q, 32'h1);
      chk(irq, 1'b1);
      wreg(efl_pkg::REG_STATUS, 32'hF);
      rreg(efl_pkg::REG_STATUS);
      chk(q, 32'h0);
      chk(irq, 1'b0);
      $display("END irq");
      cfg(5'h12);
      tx(8'h6, 6, 1, 1);
      cfg(5'h13);
      tx(8'h3, 7, 0, 1);
      chk(ne, 4);
      $display("END tx ignore");
      rx(12, 8'h55, 8'hD4, 8, 0, 0);
      chk(rf, 8'h48);
      rx(8, 8'h55, 8'hD5, 8, 0, 0);
      rx(9, 8'h55, 8'hD5, 5, 0, 0);
      cfg(5'h0C);
      rreg(efl_pkg::REG_CFG);
      chk(q, 32'h0C);
      rx(10, 8'h55, 8'hD5, 10, 0, 0);
      rx(10, 8'h54, 8'hD5, -1, 1, 0);
      rx(10, 8'h55, 8'hD4, -1, 0, 1);
      $display("END rx");
      for (int k = 0; k < 34000 && nmk < 3; k++) @(posedge clk);
      chk(mv[0], 64'hC16821003E97DE00);
      chk(mv[10], 64'h0123456789ABCDEF);
      chk(mv[19], 64'hC0F0E5003F0F1A00);
      $display("END markers");
      end_sim();
   end
endmodule // tb
`default_nettype wire
